// file: logic/bias_power_seq.sv
// Purpose: Power-up order, fault shutdown and reset generation for the bias rails.
// Assumes: Rail comparators and supply thresholds arrive as asynchronous pins.
// Notes:   Analog ramps follow the enables; this block only times them.
`timescale 1ns/1ps
`default_nettype none
module bias_power_seq #(
  parameter int unsigned TICK_CYC = bias_seq_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Supply and enable pins
  input  wire logic       supply_low_lockout_ok,
  input  wire logic       supply_detect_level_ok,
  input  wire logic       enable_in,
  // Rail comparators, bit order core, io primary, io secondary, source, gate
  input  wire logic [4:0] rail_below70,
  input  wire logic [4:0] rail_below30,
  // Configuration
  input  wire logic [1:0] io_level_select,
  input  wire logic       secondary_level_select,
  input  wire logic [2:0] logic_softstart_time,
  input  wire logic [2:0] boost_softstart_time,
  input  wire logic [3:0] gate_high_cold_target,
  input  wire logic [3:0] gate_high_hot_target,
  input  wire logic [2:0] reset_pulse_time,
  input  wire logic [2:0] boost_start_delay,
  input  wire logic       reset_threshold_select,
  // Rail controls
  output logic            io_primary_en,
  output logic            io_primary_discharge,
  output logic            io_secondary_en,
  output logic            io_secondary_level,
  output logic            core_en,
  output logic            source_en,
  output logic            gate_high_en,
  output logic [5:0]      gate_high_cold_volts,
  output logic [5:0]      gate_high_hot_volts,
  // Reset pin and status
  output logic            reset_pin_out,
  output logic            reset_pin_oe,
  output logic            fault_under,
  output logic            fault_short
);
  // ----------------------------------------
  // Synchronisers and tick divider
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_OFF, ST_LOGIC, ST_CORE, ST_RESET, ST_WAIT, ST_SRC, ST_GATE, ST_ON, ST_FAULT
  } seq_state_e;

  logic [bias_seq_pkg::NSYNC-1:0] sync_q;
  logic                           lock_ok;
  logic                           det_ok;
  logic                           en_ok;
  logic [4:0]                     b70;
  logic [4:0]                     b30;
  logic [14:0]                    div_reg;
  logic [14:0]                    div_next;
  logic                           tick;

  pin_sync3 #(.W(bias_seq_pkg::NSYNC)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({enable_in, supply_detect_level_ok, supply_low_lockout_ok,
            rail_below30, rail_below70}),
    .q    (sync_q)
  );

  assign b70     = sync_q[4:0];
  assign b30     = sync_q[9:5];
  assign lock_ok = sync_q[10];
  assign det_ok  = sync_q[11];
  assign en_ok   = sync_q[12];

  // A single divider keeps every timer on the same 0.5 ms grid.
  assign tick = (div_reg == 15'(TICK_CYC - 1));

  always_comb
  begin
    div_next = tick ? 15'h0000 : div_reg + 15'h0001;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div_reg <= 15'h0000;
    else
      div_reg <= div_next;
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  logic [bias_seq_pkg::NTMR-1:0] tmr_en;
  logic [bias_seq_pkg::NTMR-1:0] tmr_done;
  logic [7:0]                    tmr_target [bias_seq_pkg::NTMR];
  seq_state_e                    state_reg;
  seq_state_e                    state_next;
  logic                          released_reg;
  logic                          released_next;
  logic                          en_seen_reg;
  logic                          en_seen_next;
  logic                          en_drop_reg;
  logic                          en_drop_next;

  always_comb
  begin
    tmr_target[bias_seq_pkg::T_LOGIC] = {5'h00, logic_softstart_time} + 8'h01;
    tmr_target[bias_seq_pkg::T_CORE]  = {5'h00, logic_softstart_time} + 8'h01;
    tmr_target[bias_seq_pkg::T_RST]   = 8'(({5'h00, reset_pulse_time} + 8'h01)
                                          * bias_seq_pkg::RST_STEP);
    tmr_target[bias_seq_pkg::T_DLY]   = 8'({5'h00, boost_start_delay}
                                          * bias_seq_pkg::DLY_STEP);
    tmr_target[bias_seq_pkg::T_SRC]   = bias_seq_pkg::BOOST_SS0
                                        + {5'h00, boost_softstart_time};
    tmr_target[bias_seq_pkg::T_GATE]  = bias_seq_pkg::BOOST_SS0
                                        + {5'h00, boost_softstart_time};
  end

  assign tmr_en[bias_seq_pkg::T_LOGIC] = io_primary_en;
  assign tmr_en[bias_seq_pkg::T_CORE]  = core_en;
  assign tmr_en[bias_seq_pkg::T_RST]   = (state_reg == ST_RESET);
  assign tmr_en[bias_seq_pkg::T_DLY]   = (state_reg == ST_WAIT) && en_ok
                                         && released_reg && !en_drop_reg;
  assign tmr_en[bias_seq_pkg::T_SRC]   = source_en;
  assign tmr_en[bias_seq_pkg::T_GATE]  = gate_high_en;

  genvar gi;
  generate
    for (gi = 0; gi < bias_seq_pkg::NTMR; gi++)
    begin : g_tmr
      ramp_timer u_tmr (
        .clk    (clk),
        .rstn   (rstn),
        .tick   (tick),
        .en     (tmr_en[gi]),
        .target (tmr_target[gi]),
        .done   (tmr_done[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Fault supervision
  // ----------------------------------------
  logic [4:0]  mon;
  logic [4:0]  mon_raw;
  logic [19:0] mon_pipe_reg;
  logic [19:0] mon_pipe_next;
  logic [7:0] uv_cnt_reg;
  logic [7:0] uv_cnt_next;
  logic       uv_trip;
  logic       sc_trip;
  logic       fu_next;
  logic       fs_next;

  // Rails are watched only after their ramp timer (io secondary after the logic ramp), so soft-start is not a fault.
  assign mon_raw[bias_seq_pkg::R_CORE] = tmr_done[bias_seq_pkg::T_CORE];
  assign mon_raw[bias_seq_pkg::R_IOP]  = tmr_done[bias_seq_pkg::T_LOGIC];
  assign mon_raw[bias_seq_pkg::R_IOS]  = tmr_done[bias_seq_pkg::T_LOGIC] && io_secondary_en;
  assign mon_raw[bias_seq_pkg::R_SRC]  = tmr_done[bias_seq_pkg::T_SRC];
  assign mon_raw[bias_seq_pkg::R_GATE] = tmr_done[bias_seq_pkg::T_GATE];

  // The comparators lag four clocks behind the pins, so a rail is armed that much later.
  assign mon = mon_raw & mon_pipe_reg[4:0] & mon_pipe_reg[9:5]
               & mon_pipe_reg[14:10] & mon_pipe_reg[19:15];

  assign sc_trip = |(b30 & mon);
  assign uv_trip = (uv_cnt_reg > bias_seq_pkg::UV_TICKS);

  always_comb
  begin
    uv_cnt_next = uv_cnt_reg;
    mon_pipe_next = {mon_pipe_reg[14:0], mon_raw};
    if (!(|(b70 & mon)))
      uv_cnt_next = 8'h00;
    else if (tick && !uv_trip)
      uv_cnt_next = uv_cnt_reg + 8'h01;
    fu_next = uv_trip || (lock_ok && fault_under);
    fs_next = sc_trip || (lock_ok && fault_short);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      uv_cnt_reg  <= 8'h00;
      mon_pipe_reg <= 20'h00000;
      fault_under <= 1'h0;
      fault_short <= 1'h0;
    end
    else
    begin
      uv_cnt_reg  <= uv_cnt_next;
      mon_pipe_reg <= mon_pipe_next;
      fault_under <= fu_next;
      fault_short <= fs_next;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic       iop_next;
  logic       dis_next;
  logic       ios_next;
  logic       core_next;
  logic       src_next;
  logic       gate_next;
  logic [5:0] cold_v;
  logic [5:0] hot_v;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:   if (lock_ok) state_next = ST_LOGIC;
      ST_LOGIC: if (tmr_done[bias_seq_pkg::T_LOGIC]) state_next = ST_CORE;
      ST_CORE:  if (tmr_done[bias_seq_pkg::T_CORE]) state_next = ST_RESET;
      ST_RESET: if (tmr_done[bias_seq_pkg::T_RST]) state_next = ST_WAIT;
      ST_WAIT:  if (tmr_done[bias_seq_pkg::T_DLY]) state_next = ST_SRC;
      ST_SRC:   if (tmr_done[bias_seq_pkg::T_SRC]) state_next = ST_GATE;
      ST_GATE:  if (tmr_done[bias_seq_pkg::T_GATE]) state_next = ST_ON;
      ST_ON:    state_next = ST_ON;
      ST_FAULT: state_next = ST_FAULT;
      default:  state_next = ST_OFF;
    endcase
    if ((state_reg != ST_OFF) && (uv_trip || sc_trip))
      state_next = ST_FAULT;
    if (!lock_ok)
      state_next = ST_OFF;

    en_seen_next = lock_ok && (en_seen_reg || en_ok);
    en_drop_next = lock_ok && (en_drop_reg || (en_seen_reg && !en_ok));

    // Reset is pulled low again only by the chosen threshold or power-down.
    released_next = released_reg;
    if ((state_reg == ST_RESET) && tmr_done[bias_seq_pkg::T_RST])
      released_next = 1'h1;
    if ((reset_threshold_select ? !det_ok : !lock_ok) || (state_reg == ST_OFF))
      released_next = 1'h0;

    iop_next  = (state_next != ST_OFF) && (state_next != ST_FAULT);
    dis_next  = (state_next == ST_OFF);
    // Level changes toggle the regulator directly; the load shapes the edge.
    ios_next  = iop_next && (io_level_select == bias_seq_pkg::IO_2V5);
    core_next = iop_next && (state_next != ST_LOGIC);
    src_next  = !en_drop_next && en_ok && ((state_next == ST_SRC)
                || (state_next == ST_GATE) || (state_next == ST_ON));
    gate_next = !en_drop_next && en_ok
                && ((state_next == ST_GATE) || (state_next == ST_ON));

    cold_v = bias_seq_pkg::COLD_V0 + {2'h0, gate_high_cold_target};
    hot_v  = bias_seq_pkg::HOT_V0 + {2'h0, gate_high_hot_target};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg            <= ST_OFF;
      en_seen_reg          <= 1'h0;
      en_drop_reg          <= 1'h0;
      released_reg         <= 1'h0;
      io_primary_en        <= 1'h0;
      io_primary_discharge <= 1'h1;
      io_secondary_en      <= 1'h0;
      io_secondary_level   <= 1'h0;
      core_en              <= 1'h0;
      source_en            <= 1'h0;
      gate_high_en         <= 1'h0;
      gate_high_cold_volts <= bias_seq_pkg::COLD_V0;
      gate_high_hot_volts  <= bias_seq_pkg::HOT_V0;
    end
    else
    begin
      state_reg            <= state_next;
      en_seen_reg          <= en_seen_next;
      en_drop_reg          <= en_drop_next;
      released_reg         <= released_next;
      io_primary_en        <= iop_next;
      io_primary_discharge <= dis_next;
      io_secondary_en      <= ios_next;
      io_secondary_level   <= secondary_level_select;
      core_en              <= core_next;
      source_en            <= src_next;
      gate_high_en         <= gate_next;
      gate_high_cold_volts <= (cold_v < hot_v) ? hot_v : cold_v;
      gate_high_hot_volts  <= hot_v;
    end
  end

  // Open drain: the pin only ever pulls low.
  assign reset_pin_out = 1'h0;
  assign reset_pin_oe  = !released_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_sec_level_gate: assert property (io_secondary_en |->
    ($past(io_level_select) == bias_seq_pkg::IO_2V5))
    else $error("Secondary regulator on below 2.5 V level.");
  a_lockout_dis: assert property (!lock_ok |=>
    (io_primary_discharge && !io_primary_en && !gate_high_en))
    else $error("Primary rail not discharged below lockout.");
  a_core_after_io: assert property ($rose(core_en) |->
    $past(tmr_done[bias_seq_pkg::T_LOGIC]))
    else $error("Core rail started before logic ramp ended.");
  a_gate_after_src: assert property ($rose(gate_high_en) |->
    $past(tmr_done[bias_seq_pkg::T_SRC]))
    else $error("Gate-high boost started before source ramp ended.");
  a_boost_latch_off: assert property (en_drop_reg |->
    (!gate_high_en && !source_en))
    else $error("Boost enabled after enable dropped.");
  a_short_trip: assert property ((sc_trip && lock_ok && (state_reg != ST_OFF))
    |=> ((state_reg == ST_FAULT) && !io_primary_en))
    else $error("Short on a rail did not shut down at once.");
  a_under_trip: assert property ((uv_trip && lock_ok && (state_reg != ST_OFF))
    |=> (state_reg == ST_FAULT))
    else $error("Undervoltage past 50 ms did not shut down.");
  a_fault_hold: assert property (((state_reg == ST_FAULT) && lock_ok) |=>
    ((state_reg == ST_FAULT) && !core_en && !source_en))
    else $error("Device left fault without supply cycle.");
  a_reset_latch: assert property ((released_reg && lock_ok && (state_reg != ST_OFF)
    && (reset_threshold_select ? det_ok : 1'h1)) |=> !reset_pin_oe)
    else $error("Reset pin pulled low after release.");
  a_reset_in_ramp: assert property (((state_reg == ST_CORE)
    || (state_reg == ST_RESET)) |-> reset_pin_oe)
    else $error("Reset released before its pulse ended.");
  a_supply_start: assert property ($rose(io_primary_en) |->
    $past(lock_ok))
    else $error("Primary rail started without supply above lockout.");
  a_source_order: assert property ($rose(source_en) |->
    ($past(released_reg) && $past(en_ok)))
    else $error("Source boost started before enable and reset release.");
  a_short_flag_hold: assert property ((fault_short && lock_ok) |=>
    fault_short)
    else $error("Short fault flag cleared without supply cycle.");
  a_under_flag_hold: assert property ((fault_under && lock_ok) |=>
    fault_under)
    else $error("Undervoltage flag cleared without supply cycle.");
endmodule : bias_power_seq
`default_nettype wire

// file: logic/bias_seq_pkg.sv
// Purpose: Shared constants for the LCD bias power sequencer.
// Assumes: 40 MHz clock; all times are counted in 0.5 ms ticks.
// Notes:   Codes map to analog levels and times outside this block.
package bias_seq_pkg;
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned TICK_US   = 500;
  localparam int unsigned TICK_CYC  = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TW        = 8;
  localparam logic [1:0]  IO_1V7    = 2'h0;
  localparam logic [1:0]  IO_1V8    = 2'h1;
  localparam logic [1:0]  IO_2V5    = 2'h2;
  localparam logic [7:0]  BOOST_SS0 = 8'h08;
  localparam logic [7:0]  RST_STEP  = 8'h04;
  localparam logic [7:0]  DLY_STEP  = 8'h14;
  localparam logic [7:0]  UV_TICKS  = 8'h64;
  localparam logic [5:0]  COLD_V0   = 6'h19;
  localparam logic [5:0]  HOT_V0    = 6'h10;
  localparam int unsigned NRAIL     = 5;
  localparam int unsigned NTMR      = 6;
  localparam int unsigned R_CORE    = 0;
  localparam int unsigned R_IOP     = 1;
  localparam int unsigned R_IOS     = 2;
  localparam int unsigned R_SRC     = 3;
  localparam int unsigned R_GATE    = 4;
  localparam int unsigned T_LOGIC   = 0;
  localparam int unsigned T_CORE    = 1;
  localparam int unsigned T_RST     = 2;
  localparam int unsigned T_DLY     = 3;
  localparam int unsigned T_SRC     = 4;
  localparam int unsigned T_GATE    = 5;
  localparam int unsigned NSYNC     = 13;
endpackage : bias_seq_pkg

// file: logic/pin_sync3.sv
// Purpose: Three-flop input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous pins.
// Notes:   The output moves only when the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  always_comb
  begin
    q_next = q;
    for (int i = 0; i < W; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
        q_next[i] = s3_reg[i];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= q_next;
    end
  end
endmodule : pin_sync3
`default_nettype wire

// file: logic/ramp_timer.sv
// Purpose: Soft-start and delay timer counted in 0.5 ms ticks.
// Assumes: tick is a one-cycle enable from the shared divider.
// Notes:   Clearing en restarts the count from zero.
`timescale 1ns/1ps
`default_nettype none
module ramp_timer (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Control
  input  wire logic                        tick,
  input  wire logic                        en,
  input  wire logic [bias_seq_pkg::TW-1:0] target,
  // Status
  output logic                             done
);
  logic [bias_seq_pkg::TW-1:0] cnt_reg;
  logic [bias_seq_pkg::TW-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (!en)
      cnt_next = '0;
    else if (tick && !done)
      cnt_next = cnt_reg + 8'h01;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign done = en && (cnt_reg >= target);
endmodule : ramp_timer
`default_nettype wire

// file: verif/panel_model.sv
// Purpose: Far-side model of the bias rails and the panel reset line.
// Assumes: A rail sits at zero volts while its enable is low.
// Notes:   fault30 pulls a rail below both comparator levels, fault70 below the 70 level only.
`timescale 1ns/1ps
`default_nettype none
module panel_model (
  // Rail enables, bit order core, io primary, io secondary, source, gate
  input  wire logic [4:0] rail_en,
  input  wire logic [4:0] fault70,
  input  wire logic [4:0] fault30,
  // Comparators
  output logic      [4:0] rail_below70,
  output logic      [4:0] rail_below30,
  // Reset line
  input  wire logic       reset_pin_oe,
  output wire logic       reset_pin
);
  // A disabled rail reads as collapsed, so the comparators never flatter the design.
  assign rail_below70 = ~rail_en | fault70 | fault30;
  assign rail_below30 = ~rail_en | fault30;
  // The pull-up gives the high level; the device may only pull low.
  assign reset_pin = reset_pin_oe ? 1'h0 : 1'h1;
endmodule : panel_model
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the bias power sequencer.
// Assumes: TICK_CYC is 4, so one 0.5 ms tick is four clocks.
// Notes:   Delay windows allow one tick of divider alignment.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk, rstn, lock_ok, det_ok, en, sec_sel, rsel;
  logic [1:0] io_sel;
  logic [2:0] bss, lss, rpt, dly;
  logic [3:0] cold, hot;
  logic [4:0] inj70, inj30, b70, b30;
  logic       io_en, io_dis, sec_en, sec_lvl, core_en, src_en, gate_en;
  logic       rst_out, rst_oe, f_u, f_s;
  logic [5:0] cold_v, hot_v;
  logic [7:0] outs;
  wire logic  rst_pin;
  int         fails, comparisons;
  assign outs = {f_s, f_u, rst_oe, gate_en, src_en, core_en, sec_en, io_en};
  bias_power_seq #(.TICK_CYC(4)) u_dut (.clk(clk), .rstn(rstn),
    .supply_low_lockout_ok(lock_ok), .supply_detect_level_ok(det_ok), .enable_in(en),
    .rail_below70(b70), .rail_below30(b30), .io_level_select(io_sel),
    .secondary_level_select(sec_sel), .logic_softstart_time(lss),
    .boost_softstart_time(bss), .gate_high_cold_target(cold), .gate_high_hot_target(hot),
    .reset_pulse_time(rpt), .boost_start_delay(dly), .reset_threshold_select(rsel),
    .io_primary_en(io_en), .io_primary_discharge(io_dis), .io_secondary_en(sec_en),
    .io_secondary_level(sec_lvl), .core_en(core_en), .source_en(src_en),
    .gate_high_en(gate_en), .gate_high_cold_volts(cold_v), .gate_high_hot_volts(hot_v),
    .reset_pin_out(rst_out), .reset_pin_oe(rst_oe), .fault_under(f_u), .fault_short(f_s));
  panel_model u_model (.rail_en({gate_en, src_en, sec_en, io_en, core_en}),
    .fault70(inj70), .fault30(inj30), .rail_below70(b70), .rail_below30(b30),
    .reset_pin_oe(rst_oe), .reset_pin(rst_pin));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic check_rng(input string name, input int n, input int lo, input int hi);
    comparisons++;
    if (n < lo || n > hi)
    begin
      fails++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, n);
    end
  endtask : check_rng
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Polls an output until it reaches val; the bound keeps a hang visible.
  task automatic wait_bit(input int idx, input logic val, input int maxc, output int n);
    n = 0;
    while (outs[idx] !== val && n < maxc)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_bit
  task automatic report_and_stop();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic power_up(input logic [2:0] code);
    int n;
    int c;
    c = int'(code);
    @(posedge clk);
    bss <= code;
    lss <= code;
    rpt <= code;
    dly <= code;
    io_sel <= bias_seq_pkg::IO_2V5;
    en <= 1'h1;
    det_ok <= 1'h1;
    lock_ok <= 1'h1;
    wait_bit(0, 1'h1, 20, n);
    check("io_primary_en", 8'h01, io_en);
    check("io_primary_discharge", 8'h00, io_dis);
    check("io_secondary_en", 8'h01, sec_en);
    check("core_early", 8'h00, core_en);
    wait_bit(2, 1'h1, 4 * c + 20, n);
    check_rng("core_delay", n, 4 * c + 1, 4 * c + 9);
    wait_bit(5, 1'h0, 20 * c + 40, n);
    check_rng("reset_delay", n, 20 * c + 8, 20 * c + 30);
    check("reset_pin", 8'h01, rst_pin);
    check("reset_pin_out", 8'h00, rst_out);
    wait_bit(3, 1'h1, 80 * c + 20, n);
    check_rng("source_delay", n, 80 * c - 3, 80 * c + 1);
    check("gate_before_source", 8'h00, gate_en);
    wait_bit(4, 1'h1, 80, n);
    check_rng("gate_delay", n, (8 + code) * 4 - 5, (8 + code) * 4 + 5);
  endtask : power_up
  task automatic targets();
    @(posedge clk);
    cold <= 4'h2;
    hot <= 4'hF;
    cyc(8);
    check("cold_volts_low", 8'h1F, cold_v);
    check("hot_volts_top", 8'h1F, hot_v);
    @(posedge clk);
    cold <= 4'hF;
    hot <= 4'h0;
    cyc(8);
    check("cold_volts_top", 8'h28, cold_v);
    check("hot_volts_base", 8'h10, hot_v);
  endtask : targets
  task automatic levels();
    int n;
    @(posedge clk);
    sec_sel <= 1'h1;
    cyc(8);
    check("secondary_level", 8'h01, sec_lvl);
    @(posedge clk);
    io_sel <= bias_seq_pkg::IO_1V8;
    wait_bit(1, 1'h0, 8, n);
    check("secondary_off", 8'h00, sec_en);
    check("primary_kept", 8'h00, io_dis);
    @(posedge clk);
    io_sel <= bias_seq_pkg::IO_2V5;
    wait_bit(1, 1'h1, 8, n);
    check("secondary_back", 8'h01, sec_en);
  endtask : levels
  task automatic enable_drop();
    int n;
    @(posedge clk);
    en <= 1'h0;
    wait_bit(4, 1'h0, 10, n);
    check("gate_off", 8'h00, gate_en);
    check("source_off", 8'h00, src_en);
    @(posedge clk);
    en <= 1'h1;
    cyc(100);
    check("gate_latched_off", 8'h00, gate_en | src_en);
    check("reset_latched", 8'h00, rst_oe);
    check("core_kept", 8'h01, core_en);
  endtask : enable_drop
  task automatic power_down(input logic mode);
    int n;
    @(posedge clk);
    rsel <= mode;
    det_ok <= 1'h0;
    wait_bit(5, 1'h1, 12, n);
    check("reset_by_detect", {7'h00, mode}, rst_oe);
    @(posedge clk);
    lock_ok <= 1'h0;
    wait_bit(0, 1'h0, 12, n);
    check("discharge_on", 8'h01, io_dis);
    check("all_off", 8'h00, core_en | src_en | gate_en | sec_en);
    check("reset_by_lockout", 8'h01, rst_oe);
  endtask : power_down
  task automatic fault_case(input logic short_kind);
    int n;
    @(posedge clk);
    if (short_kind)
      inj30 <= 5'h08;
    else
      inj70 <= 5'h01;
    if (!short_kind)
    begin
      cyc(390);
      check("under_not_yet", 8'h01, core_en);
    end
    wait_bit(short_kind ? 7 : 6, 1'h1, short_kind ? 8 : 40, n);
    check("fault_flag", 8'h01, short_kind ? f_s : f_u);
    check("fault_all_off", 8'h00, core_en | src_en | io_en);
    @(posedge clk);
    inj30 <= 5'h00;
    inj70 <= 5'h00;
    cyc(40);
    check("fault_held", 8'h00, core_en | io_en);
    @(posedge clk);
    lock_ok <= 1'h0;
    cyc(12);
    check("fault_cleared", 8'h00, f_s | f_u);
  endtask : fault_case
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #(25 * 20000);
    fails++;
    report_and_stop();
  end
  initial
  begin
    {rstn, lock_ok, det_ok, en, sec_sel, rsel} = 6'h00;
    io_sel = bias_seq_pkg::IO_2V5;
    bss = 3'h0;
    lss = 3'h0;
    rpt = 3'h0;
    dly = 3'h0;
    cold = 4'h0;
    hot = 4'h0;
    inj70 = 5'h00;
    inj30 = 5'h00;
    fails = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    cyc(2);
    check("reset_oe_idle", 8'h01, rst_oe);
    check("discharge_idle", 8'h01, io_dis);
    power_up(3'h0);
    targets();
    levels();
    enable_drop();
    power_down(1'h1);
    power_up(3'h7);
    power_down(1'h0);
    power_up(3'h0);
    fault_case(1'h1);
    power_up(3'h0);
    fault_case(1'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
